/* hw/sar_adc_pkg.sv */
// shared types and constants for the converter control and readout block
package sar_adc_pkg;
    localparam int RESULT_W = 18;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS = 650;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRIM_CONVS = 3;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 18'h00000;
    localparam logic [RESULT_W-1:0] ALL_ONES = 18'h3FFFF;
    localparam logic [RESULT_W-1:0] CODE_SIGN = 18'h20000;
    localparam int TAIL_W = 2;
    localparam int MID_LO = 2;
    localparam int MID_W = 8;
    localparam int TAIL_LO_PIN = 2;
    localparam int TAIL_HI_PIN = 10;
    localparam int OCTET_LO_PIN = 10;

    typedef enum logic [1:0] {
        ST_SAMPLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_HOLD_IDLE = 2'b10
    } conv_state_t;

    typedef struct packed {
        logic chip_select_n;
        logic read_n;
        logic tail_bits_select;
        logic octet_shift_select;
    } bus_ctrl_t;
endpackage

/* hw/sar_adc_conversion_readout.sv */
// conversion control and parallel readout of an 18-bit sar converter
// What this block does
// - convert strobe fall with select low enters hold
// - busy high for whole conversion
// - sampling restarts on busy or select fall
// - drive pins only when select, read low
// - result in offset two's complement code
// - both selects low: full 18-bit word
// - tail select: lsbs on pins 3-2
// - octet select: bits 9-2 upper pins
// - both selects: lsbs on pins 11-10
// - multiword reads toggled or held read
// - first three conversions are trim loads
// - strobe fall with select low during conversion resets
// - select fall during conversion resets
// - reset clears latches, drops busy
// - internal timing, 650 ns conversion
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_readout
    import sar_adc_pkg::*;
#(
    parameter int CONV_COUNT = CONV_CYCLES
)(
    input wire logic clk, // 100 MHz clock
    input wire logic rst_n, // async active-low reset
    input wire logic clk_en, // freezes all state except the reset synchroniser when low
    input wire logic convert_strobe_n, // convert strobe, active low
    input wire sar_adc_pkg::bus_ctrl_t bus_ctrl, // select, read, word selects
    input wire logic [sar_adc_pkg::RESULT_W-1:0] sample_code, // quantised input
    output logic busy, // conversion in progress
    output logic sampling, // track phase active
    output logic result_valid, // result past trim conversions
    output logic [sar_adc_pkg::RESULT_W-1:0] parallel_out_pins, // data out
    output logic parallel_out_oe // high while pins are driven
);
    import sar_adc_pkg::*;

    // timer width, enough for the longest count allowed below
    localparam int COUNT_W = 13;
    localparam int COUNT_LIMIT = 4096;

    // refuse counts the conversion timer cannot hold
    if (CONV_COUNT < 1 || CONV_COUNT > COUNT_LIMIT)
    begin : g_bad_count
        $error("CONV_COUNT out of range");
    end

    // release is synchronised so every flop leaves reset on one edge
    logic rst_meta;
    logic rst_sync_n;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    conv_state_t state;
    conv_state_t next_state;
    logic [COUNT_W-1:0] count;
    logic [1:0] trim_count;
    logic strobe_prev;
    logic select_prev;
    logic [RESULT_W-1:0] held_code;
    logic [RESULT_W-1:0] result_bits;

    // edges count only on enabled cycles, so a frozen block ignores them
    wire strobe_fall = clk_en & strobe_prev & ~convert_strobe_n;
    wire select_fall = clk_en & select_prev & ~bus_ctrl.chip_select_n;
    wire in_conv = (state == ST_CONVERT);
    wire start_conv = strobe_fall & ~bus_ctrl.chip_select_n & ~in_conv;
    wire abort_strobe = strobe_fall & ~bus_ctrl.chip_select_n & in_conv;
    wire abort_select = select_fall & in_conv;
    // either abort sends the engine straight back to sampling
    wire self_reset = abort_strobe | abort_select;
    wire conv_done = in_conv & (count == COUNT_W'(CONV_COUNT - 1));

    always_comb
    begin
        next_state = state;
        case (state)
            ST_SAMPLE:
                if (start_conv)
                    next_state = ST_CONVERT;
            ST_CONVERT:
                if (self_reset)
                    next_state = ST_SAMPLE;
                else if (conv_done)
                    next_state = bus_ctrl.chip_select_n ? ST_HOLD_IDLE
                                                        : ST_SAMPLE;
            // select stayed high at the end: wait for its fall to track
            ST_HOLD_IDLE:
                if (select_fall)
                    next_state = ST_SAMPLE;
                else if (start_conv)
                    next_state = ST_CONVERT;
            default:
                next_state = ST_SAMPLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state <= ST_SAMPLE;
            strobe_prev <= 1'b1;
            select_prev <= 1'b1;
        end
        else if (clk_en)
        begin
            state <= next_state;
            strobe_prev <= convert_strobe_n;
            select_prev <= bus_ctrl.chip_select_n;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            count <= '0;
        else if (clk_en)
        begin
            if (start_conv || !in_conv)
                count <= '0;
            else
                count <= count + COUNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            held_code <= RESULT_RESET;
        else if (clk_en && start_conv)
            held_code <= sample_code;
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            result_bits <= RESULT_RESET;
        else if (clk_en)
        begin
            // an abort in the last timer cycle wins and leaves zeros
            if (self_reset)
                result_bits <= RESULT_RESET;
            else if (conv_done)
                result_bits <= held_code;
        end
    end

    // saturates, so the valid flag stays up after trim
    // count trim conversions
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            trim_count <= '0;
        else if (clk_en && conv_done && !self_reset
                 && trim_count != 2'(TRIM_CONVS))
            trim_count <= trim_count + 2'd1;
    end

    // the comb term lets busy rise in the cycle the fall is seen
    // busy follows strobe fall
    assign busy = in_conv | start_conv;
    assign sampling = (state == ST_SAMPLE) & ~start_conv;
    assign result_valid = (trim_count == 2'(TRIM_CONVS));

    logic [RESULT_W-1:0] tail_low;
    logic [RESULT_W-1:0] tail_high;
    logic [RESULT_W-1:0] octet_mid;
    always_comb
    begin
        tail_low = ALL_ONES;
        tail_high = ALL_ONES;
        octet_mid = ALL_ONES;
        tail_low[TAIL_LO_PIN +: TAIL_W] = result_bits[TAIL_W-1:0];
        tail_high[TAIL_HI_PIN +: TAIL_W] = result_bits[TAIL_W-1:0];
        octet_mid[OCTET_LO_PIN +: MID_W] = result_bits[MID_LO +: MID_W];
    end

    // read may stay low between words
    wire sel_full = ~bus_ctrl.octet_shift_select & ~bus_ctrl.tail_bits_select;
    wire sel_tail = ~bus_ctrl.octet_shift_select & bus_ctrl.tail_bits_select;
    wire sel_octet = bus_ctrl.octet_shift_select & ~bus_ctrl.tail_bits_select;
    wire [RESULT_W-1:0] slice =
        sel_full ? result_bits :
        sel_tail ? tail_low :
        sel_octet ? octet_mid : tail_high;

    // drive only on select and read
    assign parallel_out_oe = ~bus_ctrl.chip_select_n & ~bus_ctrl.read_n;
    // pins always carry the slice; oe tells the pad when they count
    assign parallel_out_pins = slice;
endmodule
`default_nettype wire

/* dv/adc_sva.sv */
// checker bound to the converter readout block
`timescale 1ns/1ps
`default_nettype none
module adc_sva
    import sar_adc_pkg::*;
#(parameter int CONV_COUNT = 65)(
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic clk_en, // clock enable
    input wire logic convert_strobe_n, // strobe
    input wire sar_adc_pkg::bus_ctrl_t bus_ctrl, // bus
    input wire logic busy, // busy
    input wire logic sampling, // track
    input wire logic [sar_adc_pkg::RESULT_W-1:0] parallel_out_pins, // data
    input wire logic parallel_out_oe // enable
);
    localparam int END_AT = CONV_COUNT + 1;
    wire logic cs = !bus_ctrl.chip_select_n;
    wire logic oe = parallel_out_oe;
    wire logic [17:0] d = parallel_out_pins;
    wire logic [1:0] sel = {bus_ctrl.tail_bits_select,
        bus_ctrl.octet_shift_select};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    oe_rule_a:
        assert property (oe == (cs && !bus_ctrl.read_n)) else $error("bad oe");
    tail_ones_a:
        assert property (oe && sel == 2'h2 |-> (d | 18'h0000C) == ALL_ONES)
        else $error("bad tail word");
    octet_ones_a:
        assert property (oe && sel == 2'h1 |-> (d | 18'h3FC00) == ALL_ONES)
        else $error("bad octet word");
    both_ones_a:
        assert property (oe && sel == 2'h3 |-> (d | 18'h00C00) == ALL_ONES)
        else $error("bad last word");
    busy_start_a:
        assert property (clk_en && $fell(convert_strobe_n) && cs
            && !$past(busy) |-> busy)
        else $error("busy late");
    busy_end_a:
        assert property ($rose(busy) |-> ##END_AT !busy) else $error("long");
    sel_abort_a:
        assert property (busy && $rose(cs) |=> !busy) else $error("no abort");
    resample_a:
        assert property ($fell(busy) && cs |-> sampling) else $error("no track");
endmodule
bind sar_adc_conversion_readout adc_sva #(.CONV_COUNT(CONV_COUNT)) i_adc_sva (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .convert_strobe_n(convert_strobe_n),
    .bus_ctrl(bus_ctrl), .busy(busy), .sampling(sampling),
    .parallel_out_pins(parallel_out_pins), .parallel_out_oe(parallel_out_oe));
`default_nettype wire

/* dv/host_strobe.sv */
// host model that pulses the convert strobe
`timescale 1ns/1ps
`default_nettype none
module host_strobe (
    input wire logic clk, // clock
    input wire logic go, // start request
    output logic convert_strobe_n // strobe
);
    logic [1:0] low_cnt = 2'h0;
    always @(posedge clk)
        if (go)
            low_cnt <= 2'h2;
        else if (low_cnt != 2'h0)
            low_cnt <= low_cnt - 2'h1;
    assign convert_strobe_n = (low_cnt == 2'h0);
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the converter readout block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sar_adc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic en = 1'b1;
    logic cv_n, busy, samp, valid, oe;
    bus_ctrl_t bc = 4'hC;
    logic [17:0] code = 18'h00000;
    logic [17:0] pins, cur;
    logic [17:0] exp_q[$];
    logic [17:0] codes[4] = '{18'h1FFFF, 18'h00000, 18'h3FFFF, 18'h20000};
    logic [31:0] lfsr = 32'h8F886D6E;
    int error_cnt = 0;
    int cmp_count = 0;
    initial forever #5 clk = ~clk;
    host_strobe i_host_strobe (.clk(clk), .go(go), .convert_strobe_n(cv_n));
    sar_adc_conversion_readout #(.CONV_COUNT(20)) i_sar_adc_conversion_readout (
        .clk(clk), .rst_n(rst_n), .clk_en(en), .convert_strobe_n(cv_n),
        .bus_ctrl(bc), .sample_code(code), .busy(busy), .sampling(samp),
        .result_valid(valid), .parallel_out_pins(pins), .parallel_out_oe(oe));
    task automatic check(input logic [17:0] got, input logic [17:0] want);
        cmp_count++;
        if (got !== want)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic close_out;
        check(18'(exp_q.size()), 18'h0);
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [17:0] slice(input logic [17:0] c,
        input logic [1:0] s);
        case (s)
            2'h0: return c;
            2'h1: return {c[9:2], 10'h3FF};
            2'h2: return {14'h3FFF, c[1:0], 2'h3};
            default: return {6'h3F, c[1:0], 10'h3FF};
        endcase
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
    endtask
    // how: 0 plain, 1 select fall aborts, 2 strobe fall aborts
    task automatic convert(input logic [17:0] c, input int how);
        code <= c;
        bc.chip_select_n <= 1'b0;
        tick(2);
        pulse();
        tick(2);
        bc.chip_select_n <= (how != 2);
        tick(3);
        if (how == 1)
            bc.chip_select_n <= 1'b0;
        if (how == 2)
            pulse();
        for (int w = 0; w < 99 && busy !== 1'b0; w++)
            tick(1);
        if (busy !== 1'b0)
        begin
            check({17'h0, busy}, 18'h0);
            close_out();
        end
        tick(4);
    endtask
    // host reads 18-, 8- or 2-bit words, clear of strobe falls
    // bus: 0 one full word, 1 two words, 2 full, octet and tail words
    task automatic read_words(input logic [17:0] c, input logic toggle,
        input int bus);
        logic [1:0] sel;
        for (int w = 0; w <= bus; w++)
        begin
            sel = (w == 0) ? 2'h0 : (bus == 1) ? 2'h2 : (w == 1) ? 2'h1 : 2'h3;
            exp_q.push_back(slice(c, sel));
            {bc.tail_bits_select, bc.octet_shift_select} <= sel;
            bc.chip_select_n <= 1'b0;
            bc.read_n <= 1'b0;
            tick(1);
            if (toggle)
            begin
                bc.read_n <= 1'b1;
                tick(1);
            end
        end
        bc.read_n <= 1'b1;
        tick(5);
    endtask
    always @(posedge clk)
        if (oe === 1'b1 && exp_q.size() > 0)
            check(pins, exp_q.pop_front());
    initial
    begin
        tick(2);
        rst_n <= 1'b1;
        tick(3);
        for (int k = 0; k < 4; k++)
        begin
            check({17'h0, valid}, {17'h0, k == TRIM_CONVS});
            convert(18'h2AAAA, 0);
        end
        $display("trim test end");
        for (int n = 0; n < 8; n++)
        begin
            lfsr = next_rand(lfsr);
            cur = (n < 4) ? codes[n] : lfsr[17:0];
            convert(cur, 0);
            check({17'h0, samp}, 18'h0);
            read_words(cur, n[0], n % 3);
            check({17'h0, samp}, 18'h1);
        end
        $display("code test end");
        bc.chip_select_n <= 1'b1;
        pulse();
        tick(4);
        check({17'h0, busy}, 18'h0);
        for (int h = 1; h < 3; h++)
        begin
            convert(18'h15A5A, h);
            read_words(18'h00000, 1'b1, h);
        end
        $display("abort test end");
        en <= 1'b0;
        pulse();
        tick(4);
        en <= 1'b1;
        tick(2);
        check({17'h0, busy}, 18'h0);
        $display("freeze test end");
        close_out();
    end
endmodule
`default_nettype wire
